// ===== rtl/octal_host_map.svh
`ifndef OCTAL_HOST_MAP_SVH
`define OCTAL_HOST_MAP_SVH

`define HOST_DATA_W 8
`define HOST_ADDR_W 6
`define REG_DEPTH 64

`define ADDR_MODE 6'h00
`define ADDR_STATUS 6'h01
`define ADDR_IMASK 6'h02
`define ADDR_ISTAT 6'h03
`define ADDR_OPCFG 6'h04
`define ADDR_TX_EN 6'h05
`define ADDR_RX_EN 6'h06
`define ADDR_CTRL 6'h07

`define CTRL_TIMER_BIT 0
`define CTRL_PDOWN_BIT 1
`define CTRL_TEST_BIT 2

`define RST_BYTE 8'h00
`define RST_ADDR 6'h00

`endif

// ===== rtl/octal_host_pkg.sv
package octal_host_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;

  typedef enum logic
  {
    MR_FIRST = 1'b0,
    MR_SECOND = 1'b1
  } mr_ptr_t;

  typedef logic [7:0] byte_t;
  typedef logic [5:0] reg_addr_t;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= INIT;
      q_o <= INIT;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// ===== rtl/strobe_edge.sv
`timescale 1ns/10ps
module strobe_edge
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic level_i,
  output logic fall_o,
  output logic rise_o
);

  logic prev_q;

  // Strobes idle high, so reset assumes high
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_q <= 1'b1;
    else if (ce_i)
      prev_q <= level_i;
  end

  assign fall_o = prev_q & ~level_i;
  assign rise_o = ~prev_q & level_i;

endmodule

// ===== rtl/octal_host_port.sv
// Functional notes
// - Chip select high: data bus released, read and write strobes ignored.
// - Data bus is eight bits, active high, bit 0 least significant.
// - With chip select low, direction follows whichever strobe is low.
// - Write strobe low: bus data stored to addressed register on rise.
// - Read strobe low: addressed register contents driven onto data bus.
// - Read begins at read strobe fall; side effects and driving start there.
// - Master reset clears status, interrupt mask, status and output config.
// - Master reset idles all receivers and transmitters; transmit lines mark.
// - Master reset stops the counter/timer until software restarts it.
// - Master reset leaves power-down and drops pending interrupt requests.
// - Master reset clears test modes; pointer back to first mode register.
`timescale 1ns/10ps
`include "octal_host_map.svh"
module octal_host_port
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire octal_host_pkg::reg_addr_t register_select_lines_i,
  input wire octal_host_pkg::byte_t host_data_bus_i,
  output octal_host_pkg::byte_t host_data_bus_o,
  output logic host_data_bus_oe_o,
  input wire octal_host_pkg::byte_t channel_status_i,
  input wire octal_host_pkg::byte_t int_event_i,
  output octal_host_pkg::byte_t interrupt_mask_o,
  output octal_host_pkg::byte_t output_port_config_o,
  output octal_host_pkg::byte_t first_mode_o,
  output octal_host_pkg::byte_t second_mode_o,
  output octal_host_pkg::byte_t tx_enable_o,
  output octal_host_pkg::byte_t rx_enable_o,
  output logic timer_run_o,
  output logic power_down_o,
  output logic test_mode_o,
  output logic mode_pointer_o,
  output logic irq_o
);
  import octal_host_pkg::*;

  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  reg_addr_t addr_s;
  byte_t data_s;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic rd_start;
  logic wr_begin;
  logic wr_commit;

  bus_state_t state_q;
  reg_addr_t addr_q;
  byte_t wdata_q;
  byte_t rdata_q;
  byte_t read_mux;
  logic oe_q;

  byte_t status_q;
  byte_t imask_q;
  byte_t istat_q;
  byte_t opcfg_q;
  byte_t mode1_q;
  byte_t mode2_q;
  byte_t tx_en_q;
  byte_t rx_en_q;
  logic timer_q;
  logic pdown_q;
  logic test_q;
  mr_ptr_t mr_ptr_q;
  logic irq_q;
  byte_t scratch_q [`REG_DEPTH];

  // Strobes and chip select reset high so no access is seen at release
  pin_sync
  #(
    .W(3),
    .INIT(3'h7)
  )
  u_strobe_sync
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({chip_select_n_i, write_strobe_n_i, read_strobe_n_i}),
    .q_o({cs_n_s, wr_n_s, rd_n_s})
  );

  // Same depth as the strobes, so data and address line up with them
  pin_sync
  #(
    .W(`HOST_ADDR_W + `HOST_DATA_W),
    .INIT(14'h0000)
  )
  u_bus_sync
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({register_select_lines_i, host_data_bus_i}),
    .q_o({addr_s, data_s})
  );

  strobe_edge u_rd_edge
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .level_i(rd_n_s),
    .fall_o(rd_fall),
    .rise_o(rd_rise)
  );

  strobe_edge u_wr_edge
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .level_i(wr_n_s),
    .fall_o(wr_fall),
    .rise_o(wr_rise)
  );

  // Both strobes low at once is illegal; neither start is taken then
  assign rd_start = (state_q == BUS_IDLE) & ~cs_n_s & rd_fall
    & wr_n_s;
  assign wr_begin = (state_q == BUS_IDLE) & ~cs_n_s & wr_fall
    & rd_n_s;
  assign wr_commit = (state_q == BUS_WRITE) & ~cs_n_s
    & wr_rise;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= BUS_IDLE;
    else if (ce_i)
    begin
      case (state_q)
        BUS_IDLE:
          if (rd_start)
            state_q <= BUS_READ;
          else if (wr_begin)
            state_q <= BUS_WRITE;
        BUS_READ:
          if (cs_n_s || rd_n_s)
            state_q <= BUS_IDLE;
        BUS_WRITE:
          // Chip select lost before the rise aborts the write
          if (cs_n_s | wr_rise)
            state_q <= BUS_IDLE;
        default:
          state_q <= BUS_IDLE;
      endcase
    end
  end

  // Address held from the start of the strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      addr_q <= `RST_ADDR;
    else if (ce_i && (rd_start || wr_begin))
      addr_q <= addr_s;
  end

  // Latest bus value while the write strobe is low
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wdata_q <= `RST_BYTE;
    else if (ce_i && (wr_begin || (state_q == BUS_WRITE && !wr_n_s)))
      wdata_q <= data_s;
  end

  always_comb
  begin
    case (addr_q)
      `ADDR_MODE:
        read_mux = (mr_ptr_q == MR_FIRST) ? mode1_q : mode2_q;
      `ADDR_STATUS:
        read_mux = status_q;
      `ADDR_IMASK:
        read_mux = imask_q;
      `ADDR_ISTAT:
        read_mux = istat_q;
      `ADDR_OPCFG:
        read_mux = opcfg_q;
      `ADDR_TX_EN:
        read_mux = tx_en_q;
      `ADDR_RX_EN:
        read_mux = rx_en_q;
      `ADDR_CTRL:
        read_mux = {5'h00, test_q, pdown_q, timer_q};
      default:
        read_mux = scratch_q[addr_q];
    endcase
  end

  // Read data refreshed each cycle, except for mode register reads, so live status is seen mid-strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= `RST_BYTE;
    else if (ce_i)
    begin
      if (rd_start)
      begin
        case (addr_s)
          `ADDR_MODE:
            rdata_q <= (mr_ptr_q == MR_FIRST) ? mode1_q : mode2_q;
          `ADDR_STATUS:
            rdata_q <= status_q;
          `ADDR_IMASK:
            rdata_q <= imask_q;
          `ADDR_ISTAT:
            rdata_q <= istat_q;
          `ADDR_OPCFG:
            rdata_q <= opcfg_q;
          `ADDR_TX_EN:
            rdata_q <= tx_en_q;
          `ADDR_RX_EN:
            rdata_q <= rx_en_q;
          `ADDR_CTRL:
            rdata_q <= {5'h00, test_q, pdown_q, timer_q};
          default:
            rdata_q <= scratch_q[addr_s];
        endcase
      end
      else if (state_q == BUS_READ && addr_q != `ADDR_MODE)
        rdata_q <= read_mux;
    end
  end

  // Driver enabled only inside a read with chip select low
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      oe_q <= 1'b0;
    else if (ce_i)
    begin
      if (rd_start)
        oe_q <= 1'b1;
      else if (cs_n_s || rd_n_s || !wr_n_s)
        oe_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      status_q <= `RST_BYTE;
    else if (ce_i)
      status_q <= channel_status_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      imask_q <= `RST_BYTE;
      opcfg_q <= `RST_BYTE;
    end
    else if (ce_i && wr_commit)
    begin
      if (addr_q == `ADDR_IMASK)
        imask_q <= wdata_q;
      if (addr_q == `ADDR_OPCFG)
        opcfg_q <= wdata_q;
    end
  end

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      istat_q <= `RST_BYTE;
    else if (ce_i)
    begin
      if (wr_commit && addr_q == `ADDR_ISTAT)
        istat_q <= (istat_q & ~wdata_q) | int_event_i;
      else
        istat_q <= istat_q | int_event_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else if (ce_i)
      irq_q <= |(istat_q & imask_q);
  end

  // Mode pointer steps at each mode access and parks at the second
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode1_q <= `RST_BYTE;
      mode2_q <= `RST_BYTE;
      mr_ptr_q <= MR_FIRST;
    end
    else if (ce_i)
    begin
      if (wr_commit && addr_q == `ADDR_MODE)
      begin
        if (mr_ptr_q == MR_FIRST)
          mode1_q <= wdata_q;
        else
          mode2_q <= wdata_q;
        mr_ptr_q <= MR_SECOND;
      end
      else if (rd_start && addr_s == `ADDR_MODE)
        mr_ptr_q <= MR_SECOND;
    end
  end

  // Channels stay idle until enabled; idle transmit lines sit at mark
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_en_q <= `RST_BYTE;
      rx_en_q <= `RST_BYTE;
    end
    else if (ce_i && wr_commit)
    begin
      if (addr_q == `ADDR_TX_EN)
        tx_en_q <= wdata_q;
      if (addr_q == `ADDR_RX_EN)
        rx_en_q <= wdata_q;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timer_q <= 1'b0;
      pdown_q <= 1'b0;
      test_q <= 1'b0;
    end
    else if (ce_i && wr_commit && addr_q == `ADDR_CTRL)
    begin
      timer_q <= wdata_q[`CTRL_TIMER_BIT];
      pdown_q <= wdata_q[`CTRL_PDOWN_BIT];
      test_q <= wdata_q[`CTRL_TEST_BIT];
    end
  end

  // Unnamed addresses are plain storage, not reset
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && wr_commit)
      scratch_q[addr_q] <= wdata_q;
  end

  assign host_data_bus_o = rdata_q;
  assign host_data_bus_oe_o = oe_q;
  assign interrupt_mask_o = imask_q;
  assign output_port_config_o = opcfg_q;
  assign first_mode_o = mode1_q;
  assign second_mode_o = mode2_q;
  assign tx_enable_o = tx_en_q;
  assign rx_enable_o = rx_en_q;
  assign timer_run_o = timer_q;
  assign power_down_o = pdown_q;
  assign test_mode_o = test_q;
  assign mode_pointer_o = mr_ptr_q;
  assign irq_o = irq_q;

endmodule

// ===== testbench/octal_host_port_asserts.sv
`timescale 1ns/10ps
module octal_host_port_asserts
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire octal_host_pkg::reg_addr_t register_select_lines_i,
  input wire octal_host_pkg::byte_t host_data_bus_i,
  input wire logic host_data_bus_oe_o,
  input wire octal_host_pkg::byte_t interrupt_mask_o,
  input wire octal_host_pkg::byte_t output_port_config_o,
  input wire octal_host_pkg::byte_t tx_enable_o,
  input wire octal_host_pkg::byte_t rx_enable_o,
  input wire logic timer_run_o,
  input wire logic power_down_o,
  input wire logic test_mode_o,
  input wire logic mode_pointer_o,
  input wire logic irq_o
);
  import octal_host_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_start;
    ce_i && $fell(read_strobe_n_i) && !chip_select_n_i && write_strobe_n_i;
  endsequence
  sequence wr_done;
    ce_i && $rose(write_strobe_n_i) && !chip_select_n_i && read_strobe_n_i;
  endsequence
  property commit_p;
    byte_t d;
    wr_done ##0 (register_select_lines_i == 6'h02, d = host_data_bus_i)
      |-> ##[1:4] interrupt_mask_o == d;
  endproperty
  bus_release_a: assert property (
    chip_select_n_i[*5] |-> !host_data_bus_oe_o)
    else $error("bus driven while deselected");
  read_drive_a: assert property (
    rd_start ##1 (!read_strobe_n_i && !chip_select_n_i)[*3]
    |-> ##[0:2] host_data_bus_oe_o)
    else $error("read did not drive bus");
  write_quiet_a: assert property (
    (!write_strobe_n_i && read_strobe_n_i && !chip_select_n_i)[*5]
    |-> !host_data_bus_oe_o)
    else $error("bus driven during write");
  write_commit_a: assert property (commit_p)
    else $error("write data not stored");
  mask_hold_a: assert property (
    (ce_i && !write_strobe_n_i)[*3] |-> $stable(interrupt_mask_o))
    else $error("register changed before strobe rise");
  reset_regs_a: assert property (
    disable iff (1'b0) rst_i |->
    interrupt_mask_o == 8'h00 && output_port_config_o == 8'h00)
    else $error("registers not cleared by reset");
  reset_chan_a: assert property (
    disable iff (1'b0) rst_i |->
    tx_enable_o == 8'h00 && rx_enable_o == 8'h00 && !timer_run_o)
    else $error("channels or timer active in reset");
  reset_mode_a: assert property (
    disable iff (1'b0) rst_i |->
    !power_down_o && !irq_o && !test_mode_o && !mode_pointer_o)
    else $error("modes not cleared by reset");
endmodule
bind octal_host_port octal_host_port_asserts chk_u (.core_clk_i, .rst_i,
  .ce_i, .chip_select_n_i, .write_strobe_n_i, .read_strobe_n_i,
  .register_select_lines_i, .host_data_bus_i, .host_data_bus_oe_o,
  .interrupt_mask_o, .output_port_config_o, .tx_enable_o, .rx_enable_o,
  .timer_run_o, .power_down_o, .test_mode_o, .mode_pointer_o, .irq_o);

// ===== testbench/host_model.sv
`timescale 1ns/10ps
module host_model
(
  input wire logic core_clk_i,
  input wire octal_host_pkg::byte_t dout_i,
  input wire logic oe_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output octal_host_pkg::reg_addr_t addr_o,
  output octal_host_pkg::byte_t bus_o
);
  import octal_host_pkg::*;
  byte_t drv_q = 8'h00;
  logic drv_on = 1'b0;
  logic flip_q = 1'b0;
  initial
  begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 6'h00;
  end
  // Undriven bus has no pull: show a changing pattern, not stale data
  always @(posedge core_clk_i)
    flip_q <= ~flip_q;
  assign bus_o = oe_i ? dout_i : (drv_on ? drv_q : {8{flip_q}});
  // Generous holds: pins pass two sync flops inside the port
  task automatic acc(input logic rd, input logic cs, input reg_addr_t a,
    input byte_t d, output byte_t q);
    @(posedge core_clk_i);
    cs_n_o <= ~cs;
    addr_o <= a;
    drv_q <= d;
    drv_on <= !rd;
    @(posedge core_clk_i);
    if (rd)
      rd_n_o <= 1'b0;
    else
      wr_n_o <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    q = bus_o;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    cs_n_o <= 1'b1;
    drv_on <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule

// ===== testbench/test_octal_host_port.sv
`timescale 1ns/10ps
module test_octal_host_port;
  import octal_host_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic ce = 1'b1;
  logic cs_n, wr_n, rd_n, oe, timer, pdown, test, ptr, irq;
  reg_addr_t addr;
  byte_t bus_in, bus_out, mask, opcfg, mode1, mode2, txe, rxe, q, flags;
  byte_t ev = 8'h00;
  reg_addr_t wa [5] = '{6'h02, 6'h04, 6'h05, 6'h06, 6'h07};
  byte_t wd [5] = '{8'ha5, 8'h96, 8'h81, 8'h6e, 8'h07};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  assign flags = {3'h0, timer, pdown, test, ptr, irq};
  initial
    forever #10 core_clk_i = ~core_clk_i;
  host_model host_u (.core_clk_i, .dout_i(bus_out), .oe_i(oe),
    .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(addr),
    .bus_o(bus_in));
  octal_host_port dut_u (.core_clk_i, .rst_i, .ce_i(ce),
    .chip_select_n_i(cs_n), .write_strobe_n_i(wr_n),
    .read_strobe_n_i(rd_n), .register_select_lines_i(addr),
    .host_data_bus_i(bus_in), .host_data_bus_o(bus_out),
    .host_data_bus_oe_o(oe), .channel_status_i(8'h3c), .int_event_i(ev),
    .interrupt_mask_o(mask), .output_port_config_o(opcfg),
    .first_mode_o(mode1), .second_mode_o(mode2), .tx_enable_o(txe),
    .rx_enable_o(rxe), .timer_run_o(timer), .power_down_o(pdown),
    .test_mode_o(test), .mode_pointer_o(ptr), .irq_o(irq));
  task automatic chk(input byte_t seen, input byte_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input reg_addr_t a, input byte_t d);
    host_u.acc(1'b0, 1'b1, a, d, q);
  endtask
  task automatic rd_chk(input reg_addr_t a, input byte_t exp);
    host_u.acc(1'b1, 1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic chk_rst();
    chk(mask, 8'h00);
    chk(opcfg, 8'h00);
    chk(txe | rxe, 8'h00);
    chk(flags, 8'h00);
    chk({7'h00, oe}, 8'h00);
  endtask
  task automatic conclude();
    $display("Checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    // Rising reset at time zero so the async reset branch really runs
    rst_i <= 1'b1;
    repeat (16) @(posedge core_clk_i);
    chk_rst();
    rst_i <= 1'b0;
    foreach (wa[i]) wr(wa[i], wd[i]);
    chk(mask, 8'ha5);
    chk(opcfg, 8'h96);
    chk(txe, 8'h81);
    chk(rxe, 8'h6e);
    chk(flags, 8'h1c);
    for (int i = 0; i < 4; i++) rd_chk(wa[i], wd[i]);
    rd_chk(6'h01, 8'h3c);
    wr(6'h2a, 8'hc3);
    rd_chk(6'h2a, 8'hc3);
    wr(6'h00, 8'h11);
    wr(6'h00, 8'h22);
    chk(mode1, 8'h11);
    chk(mode2, 8'h22);
    rd_chk(6'h00, 8'h22);
    // Clock enable low: a whole write must leave no trace
    ce <= 1'b0;
    wr(6'h02, 8'h5a);
    ce <= 1'b1;
    chk(mask, 8'ha5);
    host_u.acc(1'b0, 1'b0, 6'h02, 8'h5a, q);
    chk(mask, 8'ha5);
    host_u.acc(1'b1, 1'b0, 6'h02, 8'h00, q);
    chk({7'h00, oe}, 8'h00);
    @(posedge core_clk_i);
    ev <= 8'h03;
    @(posedge core_clk_i);
    ev <= 8'h00;
    repeat (3) @(posedge core_clk_i);
    chk(flags, 8'h1f);
    rd_chk(6'h03, 8'h03);
    wr(6'h03, 8'h01);
    rd_chk(6'h03, 8'h02);
    chk(flags, 8'h1e);
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk_rst();
    rst_i <= 1'b0;
    rd_chk(6'h03, 8'h00);
    rd_chk(6'h04, 8'h00);
    chk(flags, 8'h00);
    wr(6'h00, 8'h33);
    chk(mode1, 8'h33);
    chk(mode2, 8'h00);
    conclude();
  end
endmodule
